// ==== hw/csrc_pkg.sv ====
// package with register map, field layouts and encodings of the channel stop reaction control
package csrc_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] CSRC_OFS_CFG    = 8'h00;
    localparam logic [7:0] CSRC_OFS_CTRL   = 8'h04;
    localparam logic [7:0] CSRC_OFS_STAT   = 8'h08;
    localparam logic [7:0] CSRC_OFS_START0 = 8'h0c;
    localparam logic [7:0] CSRC_OFS_START1 = 8'h10;
    localparam logic [7:0] CSRC_OFS_CNT0   = 8'h14;
    localparam logic [7:0] CSRC_OFS_CNT1   = 8'h18;

    // ****************************************
    // per-channel config field, 8 bits each, channel n at bit 8*n
    // ****************************************
    localparam int CSRC_CH_STRIDE   = 8;
    localparam int CSRC_F_EN        = 0;
    localparam int CSRC_F_REACT     = 1;
    localparam int CSRC_F_SUB0      = 3;
    localparam int CSRC_F_SUB1      = 4;
    localparam int CSRC_F_WB_IE     = 5;
    localparam int CSRC_F_ERR_IE    = 6;
    localparam int CSRC_F_PULSE     = 7;
    localparam int CSRC_NCH         = 2;

    // ctrl register bits
    localparam int CSRC_C_LOCK      = 0;

    // status: per channel 8 bits, channel n at bit 8*n
    localparam int CSRC_S_OUT0      = 0;
    localparam int CSRC_S_OUT1      = 1;
    localparam int CSRC_S_STOP      = 2;
    localparam int CSRC_S_DIAG      = 3;
    localparam int CSRC_S_ACT       = 4;
    localparam int CSRC_S_BADCFG    = 16;

    // reset: both channels enabled, continue operation, all interrupts off
    localparam logic [31:0] CSRC_CFG_RST = 32'h0000_0101;

    // reaction to host stop
    localparam logic [1:0] CSRC_RE_CONT = 2'h0;
    localparam logic [1:0] CSRC_RE_SUBS = 2'h1;
    localparam logic [1:0] CSRC_RE_KEEP = 2'h2;

    // encoder kinds; all except other support line monitoring
    localparam logic [1:0] CSRC_ENC_PP24  = 2'h0;
    localparam logic [1:0] CSRC_ENC_RS422 = 2'h1;
    localparam logic [1:0] CSRC_ENC_SSI   = 2'h2;
    localparam logic [1:0] CSRC_ENC_OTHER = 2'h3;

    localparam logic [1:0] CSRC_RESP_OK     = 2'h0;
    localparam logic [1:0] CSRC_RESP_SLVERR = 2'h2;

endpackage

// ==== hw/csrc_top.sv ====
// channel stop reaction control: channel enable, host stop/run reaction, substitute outputs, diagnostic gating
//
// Contract
// [R1] deactivated channel never raises alarm or interrupt
// [R2] enabled channel gets address space; default enabled
// [R3] host keeps at least one channel enabled
// [R4] per-channel reaction: continue, substitute, keep last
// [R5] continue: counting keeps running during stop
// [R6] continue: outputs keep switching during stop
// [R7] substitute: drive substitute levels until run
// [R8] stop-to-run reloads start value, outputs resume; the code reloads only for substitute and keep last, not continue
// [R9] keep last: outputs frozen at stop entry
// [R10] keep last: compare pulse still expires
// [R11] first output substitute level stored, applied
// [R12] second output substitute level stored, applied
// [R13] first output status shows substitute during stop
// [R14] diagnostic interrupt only when enabled
// [R15] wire break interrupt for push-pull, rs422, ssi
// [R16] rs422 and ssi also flag short, supply
// [R17] other encoder types: no wire break interrupt
// [R18] separate enable for further operational errors
// [R19] diagnostic enables reset to disabled
// [R20] stop edges detected each clock, acted upon
// [R21] configuration frozen while channels operate
//
// The address map and the AXI4-Lite slave port were decided locally.
module csrc_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // host and channel side
    input  wire logic        host_run,
    input  wire logic [1:0]  count_pulse,
    input  wire logic [1:0]  count_dir_up,
    input  wire logic [1:0]  out0_func,
    input  wire logic [1:0]  out1_func,
    input  wire logic [1:0]  compare_hit,
    input  wire logic [3:0]  enc_type,
    input  wire logic [1:0]  fault_wire_break,
    input  wire logic [1:0]  fault_short,
    input  wire logic [1:0]  fault_supply,
    input  wire logic [1:0]  fault_other,
    output logic [1:0]       first_digital_output,
    output logic [1:0]       second_digital_output,
    output logic [1:0]       first_output_status,
    output logic [1:0]       channel_addr_valid,
    output logic [1:0]       diag_irq
);

    // ****************************************
    // constants
    // ****************************************
    localparam int          PULSE_NS     = 1000;
    localparam int          CLK_NS       = 10;
    localparam int          PULSE_CYC_I  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] PULSE_CYC    = 16'(PULSE_CYC_I);

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] cfg_q;
    logic [31:0] cfg_live_q;
    logic        lock_q;
    logic [31:0] start_q [csrc_pkg::CSRC_NCH];
    logic [31:0] cnt_q   [csrc_pkg::CSRC_NCH];
    logic        run_q;
    logic        stop_q  [csrc_pkg::CSRC_NCH];
    logic        diag_q  [csrc_pkg::CSRC_NCH];

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    logic       aw_held_q;
    logic       w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;

    wire        aw_take  = s_axi_awvalid && !aw_held_q && !bvalid_q;
    wire        w_take   = s_axi_wvalid && !w_held_q && !bvalid_q;
    wire        aw_have  = aw_held_q || aw_take;
    wire        w_have   = w_held_q || w_take;
    wire        wr_go    = aw_have && w_have && !bvalid_q;
    wire [7:0]  wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data  = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0]  wr_strb  = w_held_q ? w_strb_q : s_axi_wstrb;
    wire [31:0] wr_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire        wr_cfg   = wr_go && wr_addr == csrc_pkg::CSRC_OFS_CFG;
    wire        wr_ctrl  = wr_go && wr_addr == csrc_pkg::CSRC_OFS_CTRL;
    wire        wr_st0   = wr_go && wr_addr == csrc_pkg::CSRC_OFS_START0;
    wire        wr_st1   = wr_go && wr_addr == csrc_pkg::CSRC_OFS_START1;
    wire        wr_ro    = wr_go && (wr_addr == csrc_pkg::CSRC_OFS_STAT || wr_addr == csrc_pkg::CSRC_OFS_CNT0
                                     || wr_addr == csrc_pkg::CSRC_OFS_CNT1);
    wire        wr_ok    = wr_cfg || wr_ctrl || wr_st0 || wr_st1 || wr_ro;

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= csrc_pkg::CSRC_RESP_OK;
        end else begin
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? csrc_pkg::CSRC_RESP_OK : csrc_pkg::CSRC_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // configuration store
    // ****************************************
    // cfg writes are ignored while locked so a running channel never sees its setup change
    wire [31:0] cfg_new  = (cfg_q & ~wr_mask) | (wr_data & wr_mask);
    wire        cfg_wen  = wr_cfg && !lock_q; // [R21]

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q      <= csrc_pkg::CSRC_CFG_RST; // [R2] [R19]
            cfg_live_q <= csrc_pkg::CSRC_CFG_RST;
            lock_q     <= 1'b0;
            start_q[0] <= 32'h0000_0000;
            start_q[1] <= 32'h0000_0000;
        end else begin
            if (cfg_wen) begin
                cfg_q <= cfg_new;
            end
            if (wr_ctrl && wr_strb[0]) begin
                lock_q <= wr_data[csrc_pkg::CSRC_C_LOCK];
            end
            // live copy taken at lock time and held stable while operating
            if (!lock_q) begin
                cfg_live_q <= cfg_q; // [R21]
            end
            if (wr_st0 && !lock_q) begin
                start_q[0] <= (start_q[0] & ~wr_mask) | (wr_data & wr_mask);
            end
            if (wr_st1 && !lock_q) begin
                start_q[1] <= (start_q[1] & ~wr_mask) | (wr_data & wr_mask);
            end
        end
    end

    // ****************************************
    // host run/stop edge detection
    // ****************************************
    wire stop_edge = run_q && !host_run; // [R20]
    wire run_edge  = !run_q && host_run; // [R20]

    always_ff @(posedge mclk) begin
        if (rst) begin
            run_q <= 1'b1;
        end else begin
            run_q <= host_run;
        end
    end

    // ****************************************
    // per-channel logic
    // ****************************************
    wire  [31:0] stat_w;
    wire         bad_cfg = !cfg_live_q[csrc_pkg::CSRC_F_EN] &&
                           !cfg_live_q[csrc_pkg::CSRC_CH_STRIDE + csrc_pkg::CSRC_F_EN]; // [R3]

    for (genvar ch = 0; ch < csrc_pkg::CSRC_NCH; ch++) begin : g_ch
        localparam int B = ch * csrc_pkg::CSRC_CH_STRIDE;
        logic [15:0] pulse_q;
        logic        frz0_q;
        logic        frz1_q;
        logic        d0_q;
        logic        d1_q;
        logic        st0_q;

        wire       en      = cfg_live_q[B + csrc_pkg::CSRC_F_EN];
        wire [1:0] react   = cfg_live_q[B + csrc_pkg::CSRC_F_REACT +: 2]; // [R4]
        wire       sub0    = cfg_live_q[B + csrc_pkg::CSRC_F_SUB0]; // [R11]
        wire       sub1    = cfg_live_q[B + csrc_pkg::CSRC_F_SUB1]; // [R12]
        wire       wb_ie   = cfg_live_q[B + csrc_pkg::CSRC_F_WB_IE];
        wire       err_ie  = cfg_live_q[B + csrc_pkg::CSRC_F_ERR_IE];
        wire       pmode   = cfg_live_q[B + csrc_pkg::CSRC_F_PULSE];
        wire [1:0] enc     = enc_type[2*ch +: 2];
        wire       stopped = stop_q[ch];

        // counting runs in stop under continue; other reactions hold the count until restart
        wire       cnt_run = en && (!stopped || react == csrc_pkg::CSRC_RE_CONT); // [R5]
        wire       reload  = run_edge && react != csrc_pkg::CSRC_RE_CONT; // [R8]

        // out0 function: pulse-on-compare when pmode, else level from its function input
        wire       pulse_on = pulse_q != 16'h0000;
        wire       fn0      = pmode ? pulse_on : out0_func[ch];
        wire       fn1      = out1_func[ch];

        wire       subs_act = stopped && react == csrc_pkg::CSRC_RE_SUBS;
        wire       keep_act = stopped && react == csrc_pkg::CSRC_RE_KEEP;
        // a frozen pulse output still drops when its pulse runs out
        wire       keep0    = (pmode && frz0_q) ? pulse_on : frz0_q; // [R10]
        wire       o0       = !en ? 1'b0 : subs_act ? sub0 : keep_act ? keep0 : fn0; // [R6] [R7] [R9] [R11]
        wire       o1       = !en ? 1'b0 : subs_act ? sub1 : keep_act ? frz1_q : fn1; // [R6] [R7] [R9] [R12]

        // line monitoring only exists for push-pull, rs422 and ssi encoders
        wire       mon_ok   = enc != csrc_pkg::CSRC_ENC_OTHER; // [R17]
        wire       ext_mon  = enc == csrc_pkg::CSRC_ENC_RS422 || enc == csrc_pkg::CSRC_ENC_SSI;
        wire       wb_evt   = mon_ok && (fault_wire_break[ch] ||
                              (ext_mon && (fault_short[ch] || fault_supply[ch]))); // [R15] [R16]
        wire       irq_d    = en && ((wb_ie && wb_evt) || (err_ie && fault_other[ch])); // [R1] [R14] [R18]

        always_ff @(posedge mclk) begin
            if (rst) begin
                pulse_q   <= 16'h0000;
                frz0_q    <= 1'b0;
                frz1_q    <= 1'b0;
                d0_q      <= 1'b0;
                d1_q      <= 1'b0;
                st0_q     <= 1'b0;
                cnt_q[ch] <= 32'h0000_0000;
                stop_q[ch] <= 1'b0;
                diag_q[ch] <= 1'b0;
            end else begin
                if (stop_edge) begin
                    stop_q[ch] <= 1'b1;
                    frz0_q     <= fn0; // [R9]
                    frz1_q     <= fn1;
                end else if (run_edge) begin
                    stop_q[ch] <= 1'b0;
                end
                if (reload || !en) begin
                    pulse_q <= 16'h0000;
                end else if (compare_hit[ch] && pmode && !keep_act && !subs_act) begin
                    pulse_q <= PULSE_CYC;
                end else if (pulse_on) begin
                    pulse_q <= pulse_q - 16'h0001; // [R10]
                end
                if (reload) begin
                    cnt_q[ch] <= start_q[ch]; // [R8]
                end else if (cnt_run && count_pulse[ch]) begin
                    cnt_q[ch] <= count_dir_up[ch] ? cnt_q[ch] + 32'h0000_0001 : cnt_q[ch] - 32'h0000_0001; // [R5]
                end
                d0_q       <= o0;
                d1_q       <= o1;
                st0_q      <= o0; // [R13]
                diag_q[ch] <= irq_d;
            end
        end

        assign first_digital_output[ch]  = d0_q;
        assign second_digital_output[ch] = d1_q;
        assign first_output_status[ch]   = st0_q;
        assign diag_irq[ch]              = diag_q[ch];
        assign channel_addr_valid[ch]    = cfg_live_q[B + csrc_pkg::CSRC_F_EN]; // [R2]
        assign stat_w[B +: csrc_pkg::CSRC_CH_STRIDE] = {3'h0, en, diag_q[ch], stopped, d1_q, d0_q};
    end

    assign stat_w[31:csrc_pkg::CSRC_S_BADCFG] = {15'h0000, bad_cfg};

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire rd_take = s_axi_arvalid && !rvalid_q;
    wire [7:0] ra = s_axi_araddr;
    wire rd_hit = ra == csrc_pkg::CSRC_OFS_CFG || ra == csrc_pkg::CSRC_OFS_CTRL || ra == csrc_pkg::CSRC_OFS_STAT
                  || ra == csrc_pkg::CSRC_OFS_START0 || ra == csrc_pkg::CSRC_OFS_START1
                  || ra == csrc_pkg::CSRC_OFS_CNT0 || ra == csrc_pkg::CSRC_OFS_CNT1;
    wire [31:0] rd_mux = (ra == csrc_pkg::CSRC_OFS_CFG)    ? cfg_q :
                         (ra == csrc_pkg::CSRC_OFS_CTRL)   ? {31'h0000_0000, lock_q} :
                         (ra == csrc_pkg::CSRC_OFS_STAT)   ? stat_w :
                         (ra == csrc_pkg::CSRC_OFS_START0) ? start_q[0] :
                         (ra == csrc_pkg::CSRC_OFS_START1) ? start_q[1] :
                         (ra == csrc_pkg::CSRC_OFS_CNT0)   ? cnt_q[0] :
                         (ra == csrc_pkg::CSRC_OFS_CNT1)   ? cnt_q[1] : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= csrc_pkg::CSRC_RESP_OK;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? csrc_pkg::CSRC_RESP_OK : csrc_pkg::CSRC_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule

// ==== sim/csrc_checker.sv ====
// concurrent assertions on the ports of the channel stop reaction control
module csrc_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic [3:0] enc_type,
    input wire logic [1:0] fault_wire_break,
    input wire logic [1:0] fault_short,
    input wire logic [1:0] fault_supply,
    input wire logic [1:0] fault_other,
    input wire logic [1:0] first_digital_output,
    input wire logic [1:0] second_digital_output,
    input wire logic [1:0] first_output_status,
    input wire logic [1:0] channel_addr_valid,
    input wire logic [1:0] diag_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************************************
    // sequences
    // ****************************************
    // three cycles cover the live-config and output register lags
    sequence s_off0;
        !channel_addr_valid[0] [*3];
    endsequence
    sequence s_quiet0;
        !(fault_wire_break[0] | fault_short[0] | fault_supply[0] | fault_other[0]) [*3];
    endsequence
    sequence s_other0;
        (enc_type[1:0] == 2'h3 && !fault_other[0]) [*3];
    endsequence

    // ****************************************
    // assertions
    // ****************************************
    chk_off_silent: assert property (s_off0 |-> !diag_irq[0] && !first_digital_output[0]
        && !second_digital_output[0]) else $error("disabled channel active");
    chk_rst_state: assert property ($past(rst) |-> channel_addr_valid == 2'h3
        && diag_irq == 2'h0) else $error("bad state after reset");
    chk_status_dq: assert property (first_output_status == first_digital_output)
        else $error("output status differs from output");
    chk_quiet_irq: assert property (s_quiet0 |-> !diag_irq[0])
        else $error("interrupt without fault");
    chk_other_irq: assert property (s_other0 |-> !diag_irq[0])
        else $error("wire break interrupt on other encoder");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response missing");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped");
endmodule

bind csrc_top csrc_checker u_chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .enc_type,
    .fault_wire_break, .fault_short, .fault_supply, .fault_other, .first_digital_output, .second_digital_output,
    .first_output_status, .channel_addr_valid, .diag_irq);

// ==== sim/csrc_host_model.sv ====
// host controller model: presents run or stop after a chosen lag
module csrc_host_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       want_run,
    input  wire logic [3:0] lag,
    output logic            host_run
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // a slow host is modelled by holding the old state for lag cycles
    always_ff @(posedge mclk) begin
        if (rst || want_run == host_run) begin
            host_run <= rst ? 1'b1 : host_run;
            wait_q   <= 4'h0;
        end else if (wait_q >= lag) begin
            host_run <= want_run;
            wait_q   <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the channel stop reaction control
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst = 1'b1, want_run = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flt = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, seed = 32'h16, rd, st;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0]  count_pulse = 2'h0, out0_func = 2'h0, out1_func = 2'h0, compare_hit = 2'h0, rs;
    logic [3:0]  enc_type = 4'hf, host_lag = 4'h0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_run;
    wire  [1:0]  s_axi_bresp, s_axi_rresp, first_digital_output, second_digital_output;
    wire  [1:0]  first_output_status, channel_addr_valid, diag_irq;
    wire  [31:0] s_axi_rdata;
    wire  [31:0] outs = {26'h0, first_digital_output, 2'h0, second_digital_output};
    int          n_fail = 0, checks_done = 0, cyc = 0;

    csrc_top dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_run, .count_pulse,
        .count_dir_up(2'h3), .out0_func, .out1_func, .compare_hit, .enc_type, .fault_wire_break(flt[1:0]),
        .fault_short(flt[3:2]), .fault_supply(flt[5:4]), .fault_other(flt[7:6]), .first_digital_output,
        .second_digital_output, .first_output_status, .channel_addr_valid, .diag_irq);
    csrc_host_model u_host (.mclk, .rst, .want_run, .lag(host_lag), .host_run);

    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // kind 0 wire break, 1 short, 2 supply, 3 other error
    function automatic logic exp_diag(input int enc, input int kind, input logic [1:0] ie);
        if (kind == 3) return ie[1];
        if (kind == 0) return ie[0] && enc != 3;
        return ie[0] && (enc == 1 || enc == 2);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic test_done();
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        tick(20);
        rst <= 1'b0;
        axr(csrc_pkg::CSRC_OFS_CFG);
        cmp("cfg reset", csrc_pkg::CSRC_CFG_RST, rd);
        cmp("addr valid", 32'h3, {30'h0, channel_addr_valid});
        axw(8'h1c, 32'h0);
        cmp("unmapped bresp", {30'h0, csrc_pkg::CSRC_RESP_SLVERR}, {30'h0, rs});
        axw(csrc_pkg::CSRC_OFS_CFG, 32'h0);
        axr(csrc_pkg::CSRC_OFS_STAT);
        cmp("both off flag", 32'h1, {31'h0, rd[16]});
        cmp("rresp", 32'h0, {30'h0, rs});
        // channel 0 off with enables set, stimulated hard
        axw(csrc_pkg::CSRC_OFS_CFG, 32'h160);
        flt <= 8'hff;
        out0_func <= 2'h3;
        out1_func <= 2'h3;
        count_pulse <= 2'h3;
        tick(6);
        cmp("off channel", 32'h10, {27'h0, channel_addr_valid, diag_irq[0], first_digital_output[0],
            second_digital_output[0]});
        flt <= 8'h00;
        count_pulse <= 2'h0;
        out0_func <= 2'h0;
        out1_func <= 2'h0;
        for (int enc = 0; enc < 4; enc++) begin
            for (int kind = 0; kind < 4; kind++) begin
                seed = xs(seed);
                axw(csrc_pkg::CSRC_OFS_CFG, 32'h101 | {25'h0, seed[1:0], 5'h0});
                enc_type <= {2'h3, 2'(enc)};
                flt <= 8'h01 << (2 * kind);
                tick(4);
                cmp("diag irq", {31'h0, exp_diag(enc, kind, seed[1:0])}, {31'h0, diag_irq[0]});
                flt <= 8'h00;
                tick(4);
            end
        end
        // continue operation while stopped
        axw(csrc_pkg::CSRC_OFS_CFG, 32'h101);
        want_run <= 1'b0;
        tick(4);
        axr(csrc_pkg::CSRC_OFS_CNT0);
        st = rd + {28'h0, seed[5:2]} + 32'h1;
        repeat (seed[5:2] + 1) begin
            count_pulse <= 2'h1;
            @(posedge mclk);
            count_pulse <= 2'h0;
            @(posedge mclk);
        end
        axr(csrc_pkg::CSRC_OFS_CNT0);
        cmp("count in stop", st, rd);
        out0_func <= 2'h1;
        out1_func <= 2'h2;
        tick(4);
        cmp("continue outs", 32'h12, outs);
        // substitute on channel 0, keep last on channel 1, slow host
        want_run <= 1'b1;
        host_lag <= 4'h3;
        seed = xs(seed);
        st = seed;
        axw(csrc_pkg::CSRC_OFS_START0, st);
        axw(csrc_pkg::CSRC_OFS_CFG, 32'h050b);
        out0_func <= 2'h2;
        out1_func <= 2'h3;
        tick(10);
        want_run <= 1'b0;
        tick(10);
        cmp("stop outs", 32'h32, outs);
        cmp("out status", 32'h3, {30'h0, first_output_status});
        out0_func <= 2'h0;
        out1_func <= 2'h0;
        count_pulse <= 2'h1;
        tick(4);
        count_pulse <= 2'h0;
        cmp("held outs", 32'h32, outs);
        want_run <= 1'b1;
        tick(10);
        cmp("run outs", 32'h0, outs);
        axr(csrc_pkg::CSRC_OFS_CNT0);
        cmp("start reload", st, rd);
        // keep last with a compare pulse running into stop
        host_lag <= 4'h0;
        axw(csrc_pkg::CSRC_OFS_CFG, 32'h8501);
        compare_hit <= 2'h2;
        @(posedge mclk);
        compare_hit <= 2'h0;
        tick(3);
        want_run <= 1'b0;
        tick(4);
        cmp("pulse held", 32'h1, {31'h0, first_digital_output[1]});
        tick(100);
        cmp("pulse expired", 32'h0, {31'h0, first_digital_output[1]});
        // locked configuration ignores writes
        axw(csrc_pkg::CSRC_OFS_CTRL, 32'h1);
        axw(csrc_pkg::CSRC_OFS_CFG, 32'h0);
        tick(3);
        axr(csrc_pkg::CSRC_OFS_CFG);
        cmp("locked cfg", 32'h8501, rd);
        cmp("locked addr", 32'h3, {30'h0, channel_addr_valid});
        test_done();
    end
endmodule
